//--- design/drss_pkg.sv
`default_nettype none
package drss_pkg;
   // ==========================================
   // Channel and field geometry
   localparam int NUM_CH = 4;
   localparam int CODE_W = 5;

   // ==========================================
   // Select codes, bank clear
   localparam logic [4:0] SEL_INT_FALL = 5'h00;
   localparam logic [4:0] SEL_SOFTWARE = 5'h01;
   localparam logic [4:0] SEL_TA0 = 5'h02;
   localparam logic [4:0] SEL_TA4 = 5'h06;
   localparam logic [4:0] SEL_TB0 = 5'h07;
   localparam logic [4:0] SEL_TB2 = 5'h09;
   localparam logic [4:0] SEL_S0_TX = 5'h0a;
   localparam logic [4:0] SEL_S0_RX = 5'h0b;
   localparam logic [4:0] SEL_S2_TX = 5'h0c;
   localparam logic [4:0] SEL_S2_RX = 5'h0d;
   localparam logic [4:0] SEL_ADC = 5'h0e;
   localparam logic [4:0] SEL_S1 = 5'h0f;

   // ==========================================
   // Select codes, bank set
   localparam logic [4:0] SELB_CSP3 = 5'h05;
   localparam logic [4:0] SELB_BOTH_CSP4 = 5'h06;
   localparam logic [4:0] SELB_TB3_BOTH = 5'h07;
   localparam logic [4:0] SELB_TB4 = 5'h08;
   localparam logic [4:0] SELB_TB5 = 5'h09;
   localparam logic [4:0] SELB_INT_HI_FALL = 5'h10;

   // ==========================================
   // Reset values
   localparam logic RST_REQ = 1'b0;
   localparam logic RST_PIN = 1'b1;
endpackage
`default_nettype wire

//--- design/drss_select.sv
`timescale 1ns/1ps
`default_nettype none
module drss_select #(
   parameter int NUM_CH = drss_pkg::NUM_CH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_CH*5-1:0] request_source_code,
   input wire logic [NUM_CH-1:0] source_bank_bit,
   input wire logic [NUM_CH-1:0] external_interrupt_pin,
   input wire logic [3:0] external_interrupt_pin_hi,
   input wire logic [NUM_CH-1:0] software_request,
   input wire logic [4:0] first_group_timer,
   input wire logic [5:0] second_group_timer,
   input wire logic clocked_serial_port_3,
   input wire logic clocked_serial_port_4,
   input wire logic serial_unit_0_tx,
   input wire logic serial_unit_0_rx,
   input wire logic serial0_acknowledge_event,
   input wire logic serial_unit_1_tx,
   input wire logic serial_unit_1_rx,
   input wire logic serial1_acknowledge_event,
   input wire logic serial_unit_2_tx,
   input wire logic serial_unit_2_rx,
   input wire logic serial2_acknowledge_event,
   input wire logic adc_done,
   output logic [NUM_CH-1:0] transfer_request
);

   // ==========================================
   // Elaboration checks
   // Decode table is written for exactly four channels
   if (NUM_CH != 4) begin : g_bad_num_ch
      $error("drss_select supports exactly four channels");
   end

   // Channel slices assume five-bit select codes
   if (drss_pkg::CODE_W != 5) begin : g_bad_code_w
      $error("drss_select expects five-bit select codes");
   end

   // ==========================================
   // Pin history for edge detection
   logic [NUM_CH-1:0] pin_q;
   logic [3:0] pin_hi_q;

   // Previous levels of the per-channel pins, idle high
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_q <= {NUM_CH{drss_pkg::RST_PIN}};
      end else begin
         pin_q <= external_interrupt_pin;
      end
   end

   // Previous levels of pins 4 to 7, idle high
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_hi_q <= {4{drss_pkg::RST_PIN}};
      end else begin
         pin_hi_q <= external_interrupt_pin_hi;
      end
   end

   logic [NUM_CH-1:0] fall;
   logic [NUM_CH-1:0] both;
   logic any_hi_fall;

   // Falling edge: high last cycle, low now
   assign fall = pin_q & ~external_interrupt_pin;

   // Either edge: level differs from last cycle
   assign both = pin_q ^ external_interrupt_pin;

   // Falling edge on any one of pins 4 to 7
   assign any_hi_fall = |(pin_hi_q & ~external_interrupt_pin_hi);

   // ==========================================
   // Per-channel source multiplexer
   logic [NUM_CH-1:0] req_d;
   logic [NUM_CH-1:0] req_q;

   // One decoder per channel
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam bit ODD = (ch % 2) == 1;
      // Select slice and the two decoded candidates
      logic [4:0] code;
      logic sel_clear;
      logic sel_set;

      // Parity-resolved events
      logic rx0_evt;
      logic rx2_evt;
      logic ser1_evt;
      logic port3_evt;
      logic bank6_evt;
      logic bank7_evt;
      logic timer4_evt;
      logic timer5_evt;

      // This channel's slice of the select field
      assign code = request_source_code[ch*drss_pkg::CODE_W +: drss_pkg::CODE_W];

      // Events whose meaning depends on channel parity
      if (ODD) begin : g_odd
         assign rx0_evt = serial_unit_0_rx | serial0_acknowledge_event;
         assign rx2_evt = serial_unit_2_rx | serial2_acknowledge_event;
         assign ser1_evt = serial_unit_1_rx | serial1_acknowledge_event;
         assign port3_evt = clocked_serial_port_3;
         assign bank6_evt = clocked_serial_port_4;
         assign bank7_evt = both[ch];
         assign timer4_evt = 1'b0;
         assign timer5_evt = 1'b0;
      end else begin : g_even
         assign rx0_evt = serial_unit_0_rx;
         assign rx2_evt = serial_unit_2_rx;
         assign ser1_evt = serial_unit_1_tx;
         assign port3_evt = 1'b0;
         assign bank6_evt = both[ch];
         assign bank7_evt = second_group_timer[3];
         assign timer4_evt = second_group_timer[4];
         assign timer5_evt = second_group_timer[5];
      end

      // Bank clear decode, unlisted codes stay quiet
      always_comb begin
         sel_clear = 1'b0;
         unique case (code) inside
            drss_pkg::SEL_INT_FALL: begin
               sel_clear = fall[ch];
            end
            drss_pkg::SEL_SOFTWARE: begin
               sel_clear = software_request[ch];
            end
            [drss_pkg::SEL_TA0:drss_pkg::SEL_TA4]: begin
               sel_clear = first_group_timer[3'(code - drss_pkg::SEL_TA0)];
            end
            [drss_pkg::SEL_TB0:drss_pkg::SEL_TB2]: begin
               sel_clear = second_group_timer[3'(code - drss_pkg::SEL_TB0)];
            end
            drss_pkg::SEL_S0_TX: begin
               sel_clear = serial_unit_0_tx;
            end
            drss_pkg::SEL_S0_RX: begin
               sel_clear = rx0_evt;
            end
            drss_pkg::SEL_S2_TX: begin
               sel_clear = serial_unit_2_tx;
            end
            drss_pkg::SEL_S2_RX: begin
               sel_clear = rx2_evt;
            end
            drss_pkg::SEL_ADC: begin
               sel_clear = adc_done;
            end
            drss_pkg::SEL_S1: begin
               sel_clear = ser1_evt;
            end
            default: begin
               sel_clear = 1'b0;
            end
         endcase
      end

      // Bank set decode, unlisted codes stay quiet
      always_comb begin
         sel_set = 1'b0;
         unique case (code)
            drss_pkg::SELB_CSP3: begin
               sel_set = port3_evt;
            end
            drss_pkg::SELB_BOTH_CSP4: begin
               sel_set = bank6_evt;
            end
            drss_pkg::SELB_TB3_BOTH: begin
               sel_set = bank7_evt;
            end
            drss_pkg::SELB_TB4: begin
               sel_set = timer4_evt;
            end
            drss_pkg::SELB_TB5: begin
               sel_set = timer5_evt;
            end
            drss_pkg::SELB_INT_HI_FALL: begin
               sel_set = any_hi_fall;
            end
            default: begin
               sel_set = 1'b0;
            end
         endcase
      end

      // Bank bit chooses which decode drives the request
      assign req_d[ch] = source_bank_bit[ch] ? sel_set : sel_clear;
   end

   // ==========================================
   // Registered request outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         req_q <= {NUM_CH{drss_pkg::RST_REQ}};
      end else begin
         req_q <= req_d;
      end
   end

   // Output straight from the request flops
   assign transfer_request = req_q;

endmodule
`default_nettype wire

//--- tb/drss_select_props.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Request selection checks
module drss_select_props #(parameter int NUM_CH = 4) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_CH*5-1:0] request_source_code,
   input wire logic [NUM_CH-1:0] source_bank_bit,
   input wire logic [5:0] second_group_timer,
   input wire logic [NUM_CH-1:0] transfer_request
);
   // Per-channel views
   logic [4:0] c0, c1, c2, c3;
   logic [3:0] b, q;
   assign {c3, c2, c1, c0, b, q} = {request_source_code[19:0], source_bank_bit[3:0], transfer_request[3:0]};
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   chk_reset_quiet: assert property ($past(rst) |-> q == 4'h0) else $error("request after reset");
   chk_timer_b: assert property (!b[2] && c2 == 5'h09 |=> q[2] == $past(second_group_timer[2])) else $error("tb2");
   chk_tb3_even: assert property (b[0] && c0 == 5'h07 |=> q[0] == $past(second_group_timer[3])) else $error("tb3");
   chk_tb4_even: assert property (b[0] && c0 == 5'h08 |=> q[0] == $past(second_group_timer[4])) else $error("tb4");
   chk_port3_even: assert property (b[2] && c2 == 5'h05 |=> !q[2]) else $error("port3 even");
   chk_tb5_odd: assert property (b[1] && c1 == 5'h09 |=> !q[1]) else $error("tb5 odd");
   chk_bank_void: assert property (b[3] && c3 < 5'h05 |=> !q[3]) else $error("void code");
   chk_upper_void: assert property (!b[1] && c1[4] |=> !q[1]) else $error("upper code");
   cover property (b[1] && c1 == 5'h10 ##1 q[1]);
   cover property (!b[0] && c0 == 5'h00 ##1 q[0]);
   cover property (b[0] && c0 == 5'h06 ##1 q[0]);
endmodule
bind drss_select drss_select_props #(.NUM_CH(NUM_CH)) props (.clk, .rst, .request_source_code, .source_bank_bit,
   .second_group_timer, .transfer_request);
`default_nettype wire

//--- tb/drss_periph.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Peripheral event sources
module drss_periph (
   input wire logic clk,
   input wire logic [34:0] draw,
   output logic [34:0] e
);
   // Events follow the bench's draws, changed off the sampling edge
   initial begin
      e = '0;
      forever @(negedge clk) e <= draw;
   end
endmodule
`default_nettype wire

//--- tb/drss_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Stimulus, model and checks
module drss_select_bench;
   logic clk = 1'b0, rst = 1'b1;
   logic [19:0] code = '0;
   logic [3:0] bank = '1, tr, pp = '1, ph = '1, want = '0;
   logic [34:0] e, draw = '0;
   int errors = 0, check_count = 0;
   // Clock and event sources
   always #25 clk = ~clk;
   drss_periph periph (.clk(clk), .draw(draw), .e(e));
   drss_select dut (.clk(clk), .rst(rst), .request_source_code(code), .source_bank_bit(bank),
      .external_interrupt_pin(e[3:0]), .external_interrupt_pin_hi(e[7:4]), .software_request(e[11:8]),
      .first_group_timer(e[16:12]), .second_group_timer(e[22:17]), .clocked_serial_port_3(e[23]),
      .clocked_serial_port_4(e[24]), .serial_unit_0_tx(e[25]), .serial_unit_0_rx(e[26]),
      .serial0_acknowledge_event(e[27]), .serial_unit_1_tx(e[28]), .serial_unit_1_rx(e[29]),
      .serial1_acknowledge_event(e[30]), .serial_unit_2_tx(e[31]), .serial_unit_2_rx(e[32]),
      .serial2_acknowledge_event(e[33]), .adc_done(e[34]), .transfer_request(tr));
   // Selected source of one channel
   function automatic logic pick(int ch, logic [4:0] c, logic b);
      logic odd, both;
      odd = ch[0];
      both = pp[ch] ^ e[ch];
      if (!b) begin
         case (c) inside
            5'h00: return pp[ch] & ~e[ch];
            5'h01: return e[8 + ch];
            [5'h02:5'h09]: return e[10 + c];
            5'h0a: return e[25];
            5'h0b: return e[26] | (odd & e[27]);
            5'h0c: return e[31];
            5'h0d: return e[32] | (odd & e[33]);
            5'h0e: return e[34];
            5'h0f: return odd ? e[29] | e[30] : e[28];
            default: return 1'b0;
         endcase
      end
      case (c)
         5'h05: return odd & e[23];
         5'h06: return odd ? e[24] : both;
         5'h07: return odd ? both : e[20];
         5'h08: return ~odd & e[21];
         5'h09: return ~odd & e[22];
         5'h10: return |(ph & ~e[7:4]);
         default: return 1'b0;
      endcase
   endfunction
   // Expected requests and pin history at each edge
   always @(posedge clk) begin
      for (int ch = 0; ch < 4; ch++) want[ch] = !rst && pick(ch, code[5 * ch +: 5], bank[ch]);
      pp = rst ? 4'hf : e[3:0];
      ph = rst ? 4'hf : e[7:4];
   end
   // Compare and count
   task automatic chk(string name, logic [3:0] seen, logic [3:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic results();
      if (errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Reset, random codes, mid-run resets
   initial begin
      void'($urandom(32'h5eb7));
      repeat (16) @(negedge clk);
      rst = 1'b0;
      for (int i = 1; i < 3000; i++) begin
         @(negedge clk);
         chk("transfer_request", tr, want);
         rst = i % 1000 == 0;
         // First 64 steps sweep every code on all channels in both banks
         code = rst ? 20'h0 : i < 65 ? {4{5'(i >> 1)}} : 20'($urandom);
         bank = rst ? 4'hf : i < 65 ? {4{i[0]}} : 4'($urandom);
         draw <= 35'({$urandom, $urandom});
      end
      results();
   end
   // Watchdog
   initial begin
      #400000;
      errors++;
      results();
   end
endmodule
`default_nettype wire
